// ==== core/dra_pkg.sv ====
// constants, field layouts and carrier types for the ddr2 command/data core
package dra_pkg;
   // =========================================================
   // geometry
   localparam int NBANK  = 4;
   localparam int COLW   = 8;
   localparam int DQW    = 16;
   localparam int LANES  = 2;
   localparam int CLOSE_BIT = 10;

   // =========================================================
   // command codes {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] CMD_ACT = 4'h3;
   localparam logic [3:0] CMD_RD  = 4'h5;
   localparam logic [3:0] CMD_WR  = 4'h4;
   localparam logic [3:0] CMD_PRE = 4'h2;

   // =========================================================
   // timing, picoseconds as printed, cycles derived
   localparam int T_CLK_PS = 10000;
   localparam int T_RAS_PS = 40000;
   localparam int T_RTP_PS = 7500;
   localparam int T_RP_PS  = 15000;
   localparam int RAS_CYC  = (T_RAS_PS + T_CLK_PS - 1) / T_CLK_PS;
   localparam int RTP_CYC  = (T_RTP_PS + T_CLK_PS - 1) / T_CLK_PS;
   localparam int RP_CYC   = (T_RP_PS + T_CLK_PS - 1) / T_CLK_PS;
   localparam int PREFETCH_GAP = 2;

   // =========================================================
   // apb register map
   localparam logic [7:0] CFG_OFS  = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h04;
   localparam int CFG_AL_POS   = 0;
   localparam int CFG_CL_POS   = 4;
   localparam int CFG_BL8_POS  = 8;
   localparam int STAT_OPEN_POS = 0;
   localparam int STAT_PEND_POS = 4;
   localparam int STAT_RP_POS   = 8;
   localparam logic [3:0] AL_RST  = 4'h0;
   localparam logic [3:0] CL_RST  = 4'h3;
   localparam logic       BL8_RST = 1'b0;

   // =========================================================
   // carriers
   typedef struct packed {
      logic        cs_n;
      logic        ras_n;
      logic        cas_n;
      logic        we_n;
      logic [1:0]  bank_select_inputs;
      logic [13:0] addr;
   } dra_cmd_t;

   typedef struct packed {
      logic       bl8;
      logic [3:0] cl;
      logic [3:0] al;
   } dra_cfg_t;
endpackage

// ==== core/dra_core.sv ====
// ddr2 x16 device core: command decode, read/write bursts, auto close of rows
// Operation
// - select bit high makes read autoclose
// - autoclose starts AL+BL/2 clocks after read
// - autoclose waits for row active minimum
// - autoclose waits for read-to-precharge minimum
// - precharge period counts from actual start
// - never earlier than two clocks after prefetch
// - each byte strobe times its own byte; here both strobes follow the one shared read beat
// - write takes bank and column bits
// - write select bit closes row after burst
// - mask sampled with each data element
// - masked byte leaves array unchanged
// - read latency equals AL plus CL
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module dra_core (
   // system
   input  wire logic                 clk_i,
   input  wire logic                 sys_rst_i,
   // apb slave
   input  wire logic [7:0]           paddr_i,
   input  wire logic                 psel_i,
   input  wire logic                 penable_i,
   input  wire logic                 pwrite_i,
   input  wire logic [31:0]          pwdata_i,
   output logic [31:0]               prdata_o,
   output logic                      pready_o,
   output logic                      pslverr_o,
   // link pins
   input  wire logic                 ck_i,
   input  wire dra_pkg::dra_cmd_t    cmd_i,
   input  wire logic [15:0]          dq_i,
   input  wire logic [1:0]           write_byte_mask_i,
   output logic [15:0]               dq_o,
   output logic                      dq_oe_o,
   output logic                      lower_byte_strobe_o,
   output logic                      upper_byte_strobe_o,
   output logic                      strobe_oe_o
);
   // =========================================================
   // pin synchronisers
   logic                  ck_s1_r, ck_s2_r, ck_s3_r;
   dra_pkg::dra_cmd_t     cmd_s1_r, cmd_s2_r;
   logic [15:0]           dq_s1_r, dq_s2_r;
   logic [1:0]            mask_s1_r, mask_s2_r;

   always_ff @(posedge clk_i) begin
      ck_s1_r  <= ck_i;
      ck_s2_r  <= ck_s1_r;
      ck_s3_r  <= ck_s2_r;
      cmd_s1_r <= cmd_i;
      cmd_s2_r <= cmd_s1_r;
      dq_s1_r  <= dq_i;
      dq_s2_r  <= dq_s1_r;
      mask_s1_r <= write_byte_mask_i;
      mask_s2_r <= mask_s1_r;
   end

   logic rise, fall, edge_any;
   assign rise     = ck_s2_r & ~ck_s3_r;
   assign fall     = ~ck_s2_r & ck_s3_r;
   assign edge_any = rise | fall;

   // =========================================================
   // command decode
   logic [3:0] code;
   logic       is_act, is_rd, is_wr, is_pre, close_sel;
   logic [1:0] cmd_ba;
   logic [7:0] cmd_col;
   assign code    = {cmd_s2_r.cs_n, cmd_s2_r.ras_n, cmd_s2_r.cas_n, cmd_s2_r.we_n};
   assign is_act  = rise && code == dra_pkg::CMD_ACT;
   assign is_rd   = rise && code == dra_pkg::CMD_RD;
   assign is_wr   = rise && code == dra_pkg::CMD_WR;
   assign is_pre  = rise && code == dra_pkg::CMD_PRE;
   assign close_sel = cmd_s2_r.addr[dra_pkg::CLOSE_BIT];
   assign cmd_ba  = cmd_s2_r.bank_select_inputs;
   // only the low column bits index the small array; upper ones alias
   assign cmd_col = cmd_s2_r.addr[7:0];

   // =========================================================
   // configuration
   dra_pkg::dra_cfg_t cfg_r, cfg_nxt;
   logic [4:0] rl, wl, bl, half_bl;
   assign rl      = {1'b0, cfg_r.al} + {1'b0, cfg_r.cl};
   assign wl      = rl - 5'h01;
   assign bl      = cfg_r.bl8 ? 5'h08 : 5'h04;
   assign half_bl = cfg_r.bl8 ? 5'h04 : 5'h02;

   // =========================================================
   // burst engines
   logic [4:0] rd_wait_r, rd_wait_nxt, wr_wait_r, wr_wait_nxt;
   logic [3:0] rd_left_r, rd_left_nxt, wr_left_r, wr_left_nxt;
   logic [1:0] rd_ba_r, rd_ba_nxt, wr_ba_r, wr_ba_nxt;
   logic [7:0] rd_col_r, rd_col_nxt, wr_col_r, wr_col_nxt;
   logic       wr_close_r, wr_close_nxt;
   logic       rd_beat, wr_beat, wr_close_done;
   logic [15:0] rd_word;

   assign rd_beat = (rise && rd_wait_r == 5'h01)
                    || (edge_any && rd_wait_r == 5'h00 && rd_left_r != 4'h0);
   assign wr_beat = (rise && wr_wait_r == 5'h01)
                    || (edge_any && wr_wait_r == 5'h00 && wr_left_r != 4'h0);
   // close row once write burst ends
   assign wr_close_done = wr_beat && wr_close_r && wr_wait_r == 5'h00 && wr_left_r == 4'h1;

   always_comb begin
      rd_wait_nxt = rd_wait_r;
      rd_left_nxt = rd_left_r;
      rd_ba_nxt   = rd_ba_r;
      rd_col_nxt  = rd_col_r;
      wr_wait_nxt = wr_wait_r;
      wr_left_nxt = wr_left_r;
      wr_ba_nxt   = wr_ba_r;
      wr_col_nxt  = wr_col_r;
      wr_close_nxt = wr_close_r;
      if (rise && rd_wait_r != 5'h00) begin
         rd_wait_nxt = rd_wait_r - 5'h01;
      end
      if (rd_beat) begin
         rd_col_nxt  = rd_col_r + 8'h01;
         rd_left_nxt = (rd_wait_r == 5'h01) ? bl[3:0] - 4'h1 : rd_left_r - 4'h1;
      end
      // a new read restarts the engine; overlapping bursts are not chained
      if (is_rd) begin
         rd_wait_nxt = rl;
         rd_left_nxt = 4'h0;
         rd_ba_nxt   = cmd_ba;
         rd_col_nxt  = cmd_col;
      end
      if (rise && wr_wait_r != 5'h00) begin
         wr_wait_nxt = wr_wait_r - 5'h01;
      end
      if (wr_beat) begin
         wr_col_nxt  = wr_col_r + 8'h01;
         wr_left_nxt = (wr_wait_r == 5'h01) ? bl[3:0] - 4'h1 : wr_left_r - 4'h1;
      end
      if (is_wr) begin
         wr_wait_nxt = wl;
         wr_left_nxt = 4'h0;
         wr_ba_nxt   = cmd_ba;
         wr_col_nxt  = cmd_col;
         wr_close_nxt = close_sel;
      end
   end

   // =========================================================
   // storage, one array per byte lane
   genvar g;
   generate
      for (g = 0; g < dra_pkg::LANES; g++) begin : lane
         logic [7:0] mem [0:1023];
         // mask taken with the same beat
         always_ff @(posedge clk_i) begin
            if (wr_beat && !mask_s2_r[g]) begin
               mem[{wr_ba_r, wr_col_r}] <= dq_s2_r[g*8 +: 8];
            end
         end
         assign rd_word[g*8 +: 8] = mem[{rd_ba_r, rd_col_r}];
      end
   endgenerate

   // =========================================================
   // per-bank row state and auto close
   logic [dra_pkg::NBANK-1:0] open_v, pend_v, rp_v;
   generate
      for (g = 0; g < dra_pkg::NBANK; g++) begin : bank
         logic       open_r, open_nxt, pend_r, pend_nxt;
         logic [7:0] ras_r, ras_nxt, rtp_r, rtp_nxt, rp_r, rp_nxt;
         logic [4:0] nom_r, nom_nxt;
         logic       hit, ras_ok, rtp_ok, nom_ok, start;
         assign hit    = cmd_ba == 2'(g);
         assign ras_ok = ras_r >= 8'(dra_pkg::RAS_CYC);
         assign rtp_ok = rtp_r >= 8'(dra_pkg::RTP_CYC);
         assign nom_ok = nom_r == 5'h00 || (rise && nom_r == 5'h01);
         assign start  = pend_r && ras_ok && rtp_ok && nom_ok;
         always_comb begin
            open_nxt = open_r;
            pend_nxt = pend_r;
            nom_nxt  = nom_r;
            ras_nxt  = (ras_r == 8'hFF) ? ras_r : ras_r + 8'h01;
            rtp_nxt  = (rtp_r == 8'hFF) ? rtp_r : rtp_r + 8'h01;
            rp_nxt   = (rp_r == 8'h00) ? rp_r : rp_r - 8'h01;
            if (rise && nom_r != 5'h00) begin
               nom_nxt = nom_r - 5'h01;
            end
            // period loaded at the real start
            if (start) begin
               open_nxt = 1'b0;
               pend_nxt = 1'b0;
               rp_nxt   = 8'(dra_pkg::RP_CYC);
            end
            if (is_act && hit && rp_r == 8'h00) begin
               open_nxt = 1'b1;
               ras_nxt  = 8'h00;
            end
            if (is_rd && hit) begin
               rtp_nxt = 8'h00;
               if (close_sel) begin
                  pend_nxt = 1'b1;
                  nom_nxt  = 5'(cfg_r.al) + half_bl - 5'(dra_pkg::PREFETCH_GAP)
                             + 5'(dra_pkg::PREFETCH_GAP);
               end
            end
            if (wr_close_done && wr_ba_r == 2'(g)) begin
               pend_nxt = 1'b1;
               nom_nxt  = 5'h00;
            end
            if (is_pre && (hit || close_sel) && !pend_r) begin
               open_nxt = 1'b0;
               rp_nxt   = 8'(dra_pkg::RP_CYC);
            end
         end
         always_ff @(posedge clk_i) begin
            if (sys_rst_i) begin
               open_r <= 1'b0;
               pend_r <= 1'b0;
               nom_r  <= 5'h00;
               ras_r  <= 8'hFF;
               rtp_r  <= 8'hFF;
               rp_r   <= 8'h00;
            end else begin
               open_r <= open_nxt;
               pend_r <= pend_nxt;
               nom_r  <= nom_nxt;
               ras_r  <= ras_nxt;
               rtp_r  <= rtp_nxt;
               rp_r   <= rp_nxt;
            end
         end
         assign open_v[g] = open_r;
         assign pend_v[g] = pend_r;
         assign rp_v[g]   = rp_r != 8'h00;
      end
   endgenerate

   // =========================================================
   // pin drivers and apb
   logic [15:0] dq_nxt;
   logic        dq_oe_nxt, lstb_nxt, ustb_nxt, stb_oe_nxt;
   logic [31:0] prdata_nxt;
   logic        pready_nxt, pslverr_nxt, setup;
   assign setup = psel_i && !penable_i && !pready_o;

   always_comb begin
      dq_nxt      = dq_o;
      dq_oe_nxt   = dq_oe_o;
      lstb_nxt    = lower_byte_strobe_o;
      ustb_nxt    = upper_byte_strobe_o;
      stb_oe_nxt  = strobe_oe_o;
      cfg_nxt     = cfg_r;
      prdata_nxt  = prdata_o;
      pready_nxt  = setup;
      pslverr_nxt = 1'b0;
      if (edge_any) begin
         dq_oe_nxt  = rd_beat;
         stb_oe_nxt = rd_beat;
         // both strobes follow the same shared read beat
         lstb_nxt   = rd_beat & rise;
         ustb_nxt   = rd_beat & rise;
         dq_nxt     = rd_beat ? rd_word : 16'h0000;
      end
      if (setup) begin
         unique case (paddr_i)
            dra_pkg::CFG_OFS: begin
               prdata_nxt = 32'({cfg_r.bl8, cfg_r.cl, cfg_r.al});
            end
            dra_pkg::STAT_OFS: begin
               prdata_nxt = 32'h0000_0000;
               prdata_nxt[dra_pkg::STAT_OPEN_POS +: 4] = open_v;
               prdata_nxt[dra_pkg::STAT_PEND_POS +: 4] = pend_v;
               prdata_nxt[dra_pkg::STAT_RP_POS +: 4]   = rp_v;
            end
            default: begin
               prdata_nxt  = 32'h0000_0000;
               pslverr_nxt = 1'b1;
            end
         endcase
      end
      // write lands only at the access edge, when ready is seen high
      if (psel_i && penable_i && pready_o && pwrite_i && paddr_i == dra_pkg::CFG_OFS) begin
         cfg_nxt.al  = pwdata_i[dra_pkg::CFG_AL_POS +: 4];
         cfg_nxt.cl  = pwdata_i[dra_pkg::CFG_CL_POS +: 4];
         cfg_nxt.bl8 = pwdata_i[dra_pkg::CFG_BL8_POS];
      end
   end

   // =========================================================
   // state registers
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         rd_wait_r           <= 5'h00;
         rd_left_r           <= 4'h0;
         rd_ba_r             <= 2'h0;
         rd_col_r            <= 8'h00;
         wr_wait_r           <= 5'h00;
         wr_left_r           <= 4'h0;
         wr_ba_r             <= 2'h0;
         wr_col_r            <= 8'h00;
         wr_close_r          <= 1'b0;
         cfg_r               <= '{bl8: dra_pkg::BL8_RST, cl: dra_pkg::CL_RST, al: dra_pkg::AL_RST};
         dq_o                <= 16'h0000;
         dq_oe_o             <= 1'b0;
         lower_byte_strobe_o <= 1'b0;
         upper_byte_strobe_o <= 1'b0;
         strobe_oe_o         <= 1'b0;
         prdata_o            <= 32'h0000_0000;
         pready_o            <= 1'b0;
         pslverr_o           <= 1'b0;
      end else begin
         rd_wait_r           <= rd_wait_nxt;
         rd_left_r           <= rd_left_nxt;
         rd_ba_r             <= rd_ba_nxt;
         rd_col_r            <= rd_col_nxt;
         wr_wait_r           <= wr_wait_nxt;
         wr_left_r           <= wr_left_nxt;
         wr_ba_r             <= wr_ba_nxt;
         wr_col_r            <= wr_col_nxt;
         wr_close_r          <= wr_close_nxt;
         cfg_r               <= cfg_nxt;
         dq_o                <= dq_nxt;
         dq_oe_o             <= dq_oe_nxt;
         lower_byte_strobe_o <= lstb_nxt;
         upper_byte_strobe_o <= ustb_nxt;
         strobe_oe_o         <= stb_oe_nxt;
         prdata_o            <= prdata_nxt;
         pready_o            <= pready_nxt;
         pslverr_o           <= pslverr_nxt;
      end
   end
endmodule

// ==== dv/dra_core_props.sv ====
// bound checker: apb answers and read strobes
`timescale 1ns/1ps
module dra_props (
   // system
   input wire logic        clk_i,
   input wire logic        sys_rst_i,
   // apb
   input wire logic [7:0]  paddr_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   // link
   input wire logic        dq_oe_o,
   input wire logic        lower_byte_strobe_o,
   input wire logic        upper_byte_strobe_o,
   input wire logic        strobe_oe_o
);
   logic mapped;
   assign mapped = paddr_i == dra_pkg::CFG_OFS || paddr_i == dra_pkg::STAT_OFS;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (sys_rst_i);
   // ==========
   // apb
   sequence s_setup;
      psel_i && !penable_i;
   endsequence
   AST_APB_ANSWER: assert property (s_setup |=> pready_o)
      else $error("no ready after setup");
   AST_APB_IDLE: assert property (!(psel_i && !penable_i) |=> !pready_o)
      else $error("ready without setup");
   AST_APB_UNMAPPED: assert property (s_setup ##0 !mapped |=> pslverr_o && prdata_o == 32'h0)
      else $error("unmapped access not refused");
   AST_APB_MAPPED: assert property (s_setup ##0 mapped |=> !pslverr_o)
      else $error("mapped access refused");
   AST_ERR_READY: assert property (pslverr_o |-> pready_o)
      else $error("error without ready");
   AST_RST_QUIET: assert property (disable iff (1'b0) sys_rst_i |=> !dq_oe_o && !pready_o)
      else $error("outputs active after reset");
   // ==========
   // read strobes
   AST_STROBE_PAIR: assert property (dq_oe_o |-> lower_byte_strobe_o == upper_byte_strobe_o)
      else $error("byte strobes differ");
   AST_STROBE_OE: assert property (strobe_oe_o == dq_oe_o)
      else $error("strobe enable differs from data enable");
   AST_FIRST_RISE: assert property ($rose(dq_oe_o) |-> lower_byte_strobe_o)
      else $error("first beat not on a rise");
   AST_BEAT_HOLD: assert property (
      dq_oe_o && $changed(lower_byte_strobe_o) |=> $stable(lower_byte_strobe_o)[*2])
      else $error("strobe beat too short");
endmodule

bind dra_core dra_props dra_props_i (.*);

// ==== dv/dra_ctl_model.sv ====
// controller model: link clock, commands and write data
`timescale 1ns/1ps
module dra_ctl_model (
   // link
   output logic              ck_o,
   output dra_pkg::dra_cmd_t cmd_o,
   output logic [15:0]       dq_o,
   output logic [1:0]        mask_o
);
   localparam int TCK = 80;
   time t_cmd;

   initial begin
      ck_o = 1'b0;
      cmd_o = '1;
      dq_o = 16'h0;
      mask_o = 2'h0;
      t_cmd = 0;
   end

   // device clock runs free
   always #(TCK / 2) ck_o = ~ck_o;

   function automatic int cyc(input int ps);
      return (ps + TCK * 1000 - 1) / (TCK * 1000);
   endfunction

   task automatic settle(input int al, input int bl);
      repeat (al + bl / 2 + 2 + cyc(dra_pkg::T_RAS_PS) + cyc(dra_pkg::T_RTP_PS) + cyc(dra_pkg::T_RP_PS))
         @(posedge ck_o);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge ck_o);
   endtask

   // set on the fall so the rise finds it settled
   task automatic issue(input logic [3:0] op, input logic [1:0] ba, input logic [13:0] a);
      @(negedge ck_o);
      cmd_o <= {op, ba, a};
      @(posedge ck_o);
      t_cmd = $time;
      @(negedge ck_o);
      // released lines never keep the stale value
      cmd_o <= {4'hF, ~ba, ~a};
   endtask

   // write data one beat per edge after the command
   task automatic burst(input int wl, input int bl, input logic [15:0] d [8], input logic [1:0] m [8]);
      #(wl * TCK - TCK + TCK / 4);
      for (int k = 0; k < bl; k++) begin
         dq_o <= d[k];
         mask_o <= m[k];
         #(TCK / 2);
      end
      dq_o <= ~dq_o;
      mask_o <= ~mask_o;
   endtask
endmodule

// ==== dv/dra_core_tb.sv ====
// self-checking bench for dra_core
`timescale 1ns/1ps
module dra_core_tb;
   // ==========
   // hookup
   logic              clk_i = 1'b0;
   logic              sys_rst_i = 1'b1;
   logic [7:0]        paddr_i = 8'h00;
   logic              psel_i = 1'b0;
   logic              penable_i = 1'b0;
   logic              pwrite_i = 1'b0;
   logic [31:0]       pwdata_i = 32'h0;
   logic [31:0]       prdata_o;
   logic              pready_o;
   logic              pslverr_o;
   logic              ck_i;
   dra_pkg::dra_cmd_t cmd_i;
   logic [15:0]       dq_i;
   logic [1:0]        write_byte_mask_i;
   logic [15:0]       dq_o;
   logic              dq_oe_o;
   logic              lower_byte_strobe_o;
   logic              upper_byte_strobe_o;
   logic              strobe_oe_o;
   int                num_errors = 0;
   int                checks = 0;
   int                al, cl, bl, c;
   logic [15:0]       mem [1024];
   logic [15:0]       beats [$];
   logic              oe_q, stb_q;
   time               t_first;

   dra_core dra_core_i (.*);
   dra_ctl_model dra_ctl_model_i (.ck_o(ck_i), .cmd_o(cmd_i), .dq_o(dq_i), .mask_o(write_byte_mask_i));

   always #5 clk_i = ~clk_i;

   // a beat is a new strobe level while driving
   always @(posedge clk_i) begin
      oe_q <= dq_oe_o;
      stb_q <= lower_byte_strobe_o;
      if (dq_oe_o === 1'b1 && (oe_q !== 1'b1 || stb_q !== lower_byte_strobe_o)) begin
         if (beats.size() == 0)
            t_first = $time;
         beats.push_back(dq_o);
      end
   end

   task automatic stop_test;
      $display("TB: errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int n;
      n = 0;
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      @(posedge clk_i);
      while (pready_o !== 1'b1 && n < 50) begin
         n++;
         @(posedge clk_i);
      end
      chk(n < 50, 1);
      q = prdata_o;
      e = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask

   task automatic stat(output logic [31:0] q);
      logic e;
      apb(1'b0, dra_pkg::STAT_OFS, 32'h0, q, e);
   endtask

   task automatic act(input int b);
      dra_ctl_model_i.issue(dra_pkg::CMD_ACT, 2'(b), 14'($urandom));
      dra_ctl_model_i.idle(2);
   endtask

   task automatic wr(input int b, input logic cls, input logic [1:0] mk);
      logic [15:0] d [8];
      logic [1:0]  m [8];
      for (int k = 0; k < 8; k++) begin
         d[k] = 16'($urandom);
         m[k] = mk & 2'($urandom);
      end
      dra_ctl_model_i.issue(dra_pkg::CMD_WR, 2'(b), {3'($urandom), cls, 10'(c)});
      dra_ctl_model_i.burst(al + cl - 1, bl, d, m);
      for (int k = 0; k < bl; k++) begin
         if (!m[k][0])
            mem[b * 256 + c + k][7:0] = d[k][7:0];
         if (!m[k][1])
            mem[b * 256 + c + k][15:8] = d[k][15:8];
      end
      dra_ctl_model_i.settle(al, bl);
   endtask

   task automatic rd(input int b);
      logic [31:0] q;
      beats.delete();
      dra_ctl_model_i.issue(dra_pkg::CMD_RD, 2'(b), {3'($urandom), 1'b1, 10'(c)});
      dra_ctl_model_i.idle(al + bl / 2 - 1);
      stat(q);
      chk({q[dra_pkg::STAT_OPEN_POS + b], q[dra_pkg::STAT_PEND_POS + b]}, 2'b11);
      dra_ctl_model_i.idle(2);
      stat(q);
      chk(q[dra_pkg::STAT_OPEN_POS + b], 1'b0);
      dra_ctl_model_i.idle(cl + 2);
      chk(beats.size(), bl);
      chk(32'((t_first - dra_ctl_model_i.t_cmd) / 80), al + cl);
      for (int k = 0; k < bl; k++)
         chk(beats[k], mem[b * 256 + c + k]);
      dra_ctl_model_i.settle(al, bl);
   endtask

   initial begin
      #300000;
      num_errors++;
      stop_test();
   end

   initial begin
      logic [31:0] q;
      logic        e;
      void'($urandom(39034));
      repeat (6) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      apb(1'b1, 8'h0C, 32'hFFFFFFFF, q, e);
      chk(e, 1'b1);
      apb(1'b0, 8'h0C, 32'h0, q, e);
      chk({e, q[30:0]}, 32'h80000000);
      apb(1'b1, dra_pkg::STAT_OFS, 32'hFFFFFFFF, q, e);
      stat(q);
      chk(q, 32'h0);
      apb(1'b0, dra_pkg::CFG_OFS, 32'h0, q, e);
      chk(q, {23'h0, dra_pkg::BL8_RST, dra_pkg::CL_RST, dra_pkg::AL_RST});
      for (int md = 0; md < 2; md++) begin
         al = md;
         cl = 3 + md;
         bl = 4 + 4 * md;
         c = 8 * ($urandom % 32);
         apb(1'b1, dra_pkg::CFG_OFS, {23'h0, md[0], 4'(cl), 4'(al)}, q, e);
         apb(1'b0, dra_pkg::CFG_OFS, 32'h0, q, e);
         chk(q, {23'h0, md[0], 4'(cl), 4'(al)});
         // all banks first, so a wrong bank decode shows on read back
         for (int b = 0; b < 4; b++) begin
            act(b);
            wr(b, 1'b0, 2'h0);
            wr(b, b[0], 2'h3);
            stat(q);
            chk(q[dra_pkg::STAT_OPEN_POS + b], !b[0]);
         end
         for (int b = 0; b < 4; b++) begin
            if (b[0])
               act(b);
            rd(b);
         end
      end
      stop_test();
   end
endmodule
